// ---- hdl/ddm_defs.svh ----
`ifndef DDM_DEFS_SVH
`define DDM_DEFS_SVH

// register byte offsets
`define DDM_REG_CTRL 8'h00
`define DDM_REG_STATUS 8'h04
`define DDM_REG_WORD_LO 8'h40
`define DDM_REG_WORD_HI 8'hbc
`define DDM_CTRL_RESET 32'h0000_0000

// control fields
`define DDM_F_DEC 3:0
`define DDM_F_BYPASS 4
`define DDM_F_DIGMUX 5
`define DDM_F_SELPIN 6
`define DDM_F_SEL_A 8:7
`define DDM_F_SEL_B 10:9

// status fields
`define DDM_S_OVERRUN 0
`define DDM_S_NONDET 1
`define DDM_S_FLUSH 2
`define DDM_S_BADCFG 3

// total latency in device clock cycles per decimation option
`define DDM_LAT_BYPASS 424
`define DDM_LAT_D4 516
`define DDM_LAT_D6 746
`define DDM_LAT_D8 621
`define DDM_LAT_D9 764
`define DDM_LAT_D10 811
`define DDM_LAT_D12 897
`define DDM_LAT_D16 1045
`define DDM_LAT_D18 1164
`define DDM_LAT_D20 1256
`define DDM_LAT_D24 1443
`define DDM_LAT_D32 1773
`define DDM_LAT_MAX 1773

// register stages outside the delay line on the sample path
`define DDM_PIPE 5

`endif

// ---- hdl/ddm_pkg.sv ----
package ddm_pkg;

    typedef enum logic [3:0] {
        DDM_DEC_4, DDM_DEC_6, DDM_DEC_8, DDM_DEC_9, DDM_DEC_10, DDM_DEC_12,
        DDM_DEC_16, DDM_DEC_18, DDM_DEC_20, DDM_DEC_24, DDM_DEC_32
    } ddm_dec_t;

    typedef enum logic {
        DDM_BUS_WAIT,
        DDM_BUS_ACK
    } ddm_bus_t;

    typedef logic [2:0][15:0] ddm_words_t;

endpackage : ddm_pkg

// ---- hdl/ddm_mix_if.sv ----
`timescale 1ns/1ps
interface ddm_mix_if;
    import ddm_pkg::*;
    logic signed [13:0] sample;
    logic enable;
    logic [1:0] sel;
    ddm_words_t word;
    logic signed [15:0] i_out;
    logic signed [15:0] q_out;
    modport mixer (input sample, enable, sel, word, output i_out, q_out);
    modport ctrl (output sample, enable, sel, word, input i_out, q_out);
endinterface : ddm_mix_if

// ---- hdl/ddm_mixer.sv ----
`timescale 1ns/1ps
module ddm_mixer
    import ddm_pkg::*;
#(
    parameter int NOSC = 3
) (
    input wire logic clk,
    input wire logic srst,
    ddm_mix_if.mixer m
);

    if (NOSC < 1 || NOSC > 3) $error("ddm_mixer: NOSC must be 1 to 3");

    logic [15:0] phase_ff [NOSC];
    logic [15:0] nxt_phase [NOSC];
    logic signed [15:0] i_ff, q_ff, nxt_i, nxt_q;

    // quarter-wave sine, 16 points, signed 16-bit amplitude
    function automatic logic signed [15:0] sine6(input logic [5:0] p);
        logic [3:0] k;
        logic [15:0] t;
        k = p[4] ? ~p[3:0] : p[3:0];
        case (k)
            4'h0: t = 16'h0000;
            4'h1: t = 16'h0c8c;
            4'h2: t = 16'h18f9;
            4'h3: t = 16'h2528;
            4'h4: t = 16'h30fb;
            4'h5: t = 16'h3c56;
            4'h6: t = 16'h471c;
            4'h7: t = 16'h5133;
            4'h8: t = 16'h5a82;
            4'h9: t = 16'h62f1;
            4'ha: t = 16'h6a6d;
            4'hb: t = 16'h70e2;
            4'hc: t = 16'h7641;
            4'hd: t = 16'h7a7c;
            4'he: t = 16'h7d89;
            default: t = 16'h7f61;
        endcase
        return p[5] ? -$signed(t) : $signed(t);
    endfunction : sine6

    // every accumulator runs whenever enable is high, whatever sel, so a switch keeps phase continuity; enable low clears it
    for (genvar g = 0; g < NOSC; g++) begin : g_acc
        always_comb begin
            nxt_phase[g] = m.enable ? phase_ff[g] + m.word[g] : 16'h0000;
        end
        always_ff @(posedge clk) begin
            if (srst) begin
                phase_ff[g] <= 16'h0000;
            end else begin
                phase_ff[g] <= nxt_phase[g];
            end
        end
    end

    always_comb begin
        logic [15:0] ph;
        logic signed [29:0] pi, pq;
        ph = phase_ff[0];
        for (int k = 1; k < NOSC; k++) begin
            if (m.sel == 2'(k)) begin
                ph = phase_ff[k];
            end
        end
        // x * e^(-j w n): cos on i, negated sine on q
        pi = m.sample * sine6(6'(ph[15:10] + 6'h10));
        pq = -(m.sample * sine6(ph[15:10]));
        nxt_i = pi[28:13];
        nxt_q = pq[28:13];
        if (!m.enable || m.sel == 2'h3 || int'(m.sel) >= NOSC) begin
            nxt_i = 16'sh0000;
            nxt_q = 16'sh0000;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            i_ff <= 16'sh0000;
            q_ff <= 16'sh0000;
        end else begin
            i_ff <= nxt_i;
            q_ff <= nxt_q;
        end
    end

    assign m.i_out = i_ff;
    assign m.q_out = q_ff;

endmodule : ddm_mixer

// ---- hdl/ddm_top.sv ----
// Our own choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`include "ddm_defs.svh"
module ddm_top
    import ddm_pkg::*;
#(
    parameter int LINE_DEPTH = 2048
) (
    input wire logic CLOCK,
    input wire logic SRST,
    input wire logic [7:0] ADDRESS,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [31:0] WRITEDATA,
    output logic [31:0] READDATA,
    output logic WAITREQUEST,
    input wire logic [13:0] ADC_A,
    input wire logic [13:0] ADC_B,
    input wire logic [1:0] OSC_SEL_A_PIN,
    input wire logic [1:0] OSC_SEL_B_PIN,
    input wire logic LINK_UP,
    output logic [127:0] OUT_DATA,
    output logic OUT_VALID,
    input wire logic OUT_READY
);

    localparam int AW = $clog2(LINE_DEPTH);
    if (LINE_DEPTH < `DDM_LAT_MAX || 2 ** AW != LINE_DEPTH) $error("ddm_top: bad LINE_DEPTH");

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic [5:0] dec_ratio(input ddm_dec_t d);
        case (d)
            DDM_DEC_6: return 6'd6;
            DDM_DEC_8: return 6'd8;
            DDM_DEC_9: return 6'd9;
            DDM_DEC_10: return 6'd10;
            DDM_DEC_12: return 6'd12;
            DDM_DEC_16: return 6'd16;
            DDM_DEC_18: return 6'd18;
            DDM_DEC_20: return 6'd20;
            DDM_DEC_24: return 6'd24;
            DDM_DEC_32: return 6'd32;
            default: return 6'd4;
        endcase
    endfunction : dec_ratio

    function automatic logic [10:0] dec_latency(input ddm_dec_t d, input logic byp);
        if (byp) return 11'(`DDM_LAT_BYPASS);
        case (d)
            DDM_DEC_6: return 11'(`DDM_LAT_D6);
            DDM_DEC_8: return 11'(`DDM_LAT_D8);
            DDM_DEC_9: return 11'(`DDM_LAT_D9);
            DDM_DEC_10: return 11'(`DDM_LAT_D10);
            DDM_DEC_12: return 11'(`DDM_LAT_D12);
            DDM_DEC_16: return 11'(`DDM_LAT_D16);
            DDM_DEC_18: return 11'(`DDM_LAT_D18);
            DDM_DEC_20: return 11'(`DDM_LAT_D20);
            DDM_DEC_24: return 11'(`DDM_LAT_D24);
            DDM_DEC_32: return 11'(`DDM_LAT_D32);
            default: return 11'(`DDM_LAT_D4);
        endcase
    endfunction : dec_latency

    // gain scaling of the boxcar sum: shift by ceil(log2(ratio)); a boxcar trades alias
    // rejection for size
    function automatic logic [2:0] dec_shift(input logic [5:0] r);
        if (r <= 6'd4) return 3'd2;
        else if (r <= 6'd8) return 3'd3;
        else if (r <= 6'd16) return 3'd4;
        else return 3'd5;
    endfunction : dec_shift

    ////////////////////////////////////////////////////////////////////////////
    // register bus

    ddm_bus_t bus_ff, nxt_bus;
    logic [31:0] ctrl_ff, nxt_ctrl, rdata_ff, nxt_rdata, rd_val;
    logic [7:0] byte_ff [32];
    logic overrun_ff, nxt_overrun, nondet_ff, nxt_nondet, overrun_set;
    logic flushing, bad_cfg, take_wr, clr_wr;
    logic [4:0] widx;

    assign take_wr = WRITE && bus_ff == DDM_BUS_ACK;
    assign widx = 5'((ADDRESS - `DDM_REG_WORD_LO) >> 2);
    assign clr_wr = take_wr && ADDRESS == `DDM_REG_STATUS;

    always_comb begin
        rd_val = 32'h0000_0000;
        if (ADDRESS == `DDM_REG_CTRL) begin
            rd_val = ctrl_ff;
        end else if (ADDRESS == `DDM_REG_STATUS) begin
            rd_val = {28'h000_0000, bad_cfg, flushing, nondet_ff, overrun_ff};
        end else if (ADDRESS >= `DDM_REG_WORD_LO && ADDRESS <= `DDM_REG_WORD_HI) begin
            rd_val = {24'h00_0000, byte_ff[widx]};
        end
    end

    // one wait cycle per access; idle waitrequest stays high
    always_comb begin
        nxt_bus = DDM_BUS_WAIT;
        nxt_rdata = rdata_ff;
        nxt_ctrl = ctrl_ff;
        if ((READ || WRITE) && bus_ff == DDM_BUS_WAIT) begin
            nxt_bus = DDM_BUS_ACK;
            nxt_rdata = READ ? rd_val : 32'h0000_0000;
        end
        if (take_wr && ADDRESS == `DDM_REG_CTRL) begin
            nxt_ctrl = {21'h00_0000, WRITEDATA[10:0]};
        end
        // set wins over a simultaneous write-one clear
        nxt_overrun = overrun_set || (overrun_ff && !(clr_wr && WRITEDATA[`DDM_S_OVERRUN]));
        nxt_nondet = (take_wr && LINK_UP && ADDRESS >= `DDM_REG_WORD_LO
                      && ADDRESS <= `DDM_REG_WORD_HI)
                     || (nondet_ff && !(clr_wr && WRITEDATA[`DDM_S_NONDET]));
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            bus_ff <= DDM_BUS_WAIT;
            rdata_ff <= 32'h0000_0000;
            ctrl_ff <= `DDM_CTRL_RESET;
            overrun_ff <= 1'b0;
            nondet_ff <= 1'b0;
        end else begin
            bus_ff <= nxt_bus;
            rdata_ff <= nxt_rdata;
            ctrl_ff <= nxt_ctrl;
            overrun_ff <= nxt_overrun;
            nondet_ff <= nxt_nondet;
        end
    end

    // frequency words, one byte register per half
    for (genvar g = 0; g < 32; g++) begin : g_byte
        logic [7:0] nxt_byte;
        always_comb begin
            nxt_byte = byte_ff[g];
            if (take_wr && ADDRESS == 8'(`DDM_REG_WORD_LO + 4 * g)) begin
                nxt_byte = WRITEDATA[7:0];
            end
        end
        always_ff @(posedge CLOCK) begin
            if (SRST) begin
                byte_ff[g] <= 8'h00;
            end else begin
                byte_ff[g] <= nxt_byte;
            end
        end
    end

    assign READDATA = rdata_ff;
    assign WAITREQUEST = (bus_ff == DDM_BUS_WAIT);

    ////////////////////////////////////////////////////////////////////////////
    // configuration and input stage

    ddm_dec_t dec;
    logic bypass, wide;
    logic [5:0] ratio;
    logic [10:0] latency;
    logic [1:0] sel_a, sel_b;
    logic signed [13:0] smp_a_ff, smp_b_ff;
    logic signed [13:0] nxt_smp_a, nxt_smp_b;

    assign bad_cfg = ctrl_ff[`DDM_F_DEC] > 4'(DDM_DEC_32);
    // an unknown ratio code falls back to divide-by-4
    assign dec = bad_cfg ? DDM_DEC_4 : ddm_dec_t'(ctrl_ff[`DDM_F_DEC]);
    assign bypass = ctrl_ff[`DDM_F_BYPASS];
    assign ratio = dec_ratio(dec);
    assign wide = (dec == DDM_DEC_4 || dec == DDM_DEC_6);
    assign latency = dec_latency(dec, bypass);
    assign sel_a = ctrl_ff[`DDM_F_SELPIN] ? OSC_SEL_A_PIN : ctrl_ff[`DDM_F_SEL_A];
    assign sel_b = ctrl_ff[`DDM_F_SELPIN] ? OSC_SEL_B_PIN : ctrl_ff[`DDM_F_SEL_B];

    always_comb begin
        nxt_smp_a = ADC_A;
        nxt_smp_b = ctrl_ff[`DDM_F_DIGMUX] ? ADC_A : ADC_B;
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            smp_a_ff <= 14'sh0000;
            smp_b_ff <= 14'sh0000;
        end else begin
            smp_a_ff <= nxt_smp_a;
            smp_b_ff <= nxt_smp_b;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mixers: band b is channel b/2, DDC b%2

    logic signed [15:0] mix_i [4];
    logic signed [15:0] mix_q [4];

    for (genvar b = 0; b < 4; b++) begin : g_band
        localparam int DDC = b % 2;
        localparam int WB = (b / 2) * 16 + DDC * 8;
        ddm_mix_if mif ();
        assign mif.sample = (b / 2 == 0) ? smp_a_ff : smp_b_ff;
        assign mif.enable = !bypass && !(DDC == 1 && wide);
        assign mif.sel = (DDC == 1) ? 2'h0 : ((b / 2 == 0) ? sel_a : sel_b);
        for (genvar k = 0; k < 3; k++) begin : g_word
            assign mif.word[k] = {byte_ff[WB + 2 * k + 1], byte_ff[WB + 2 * k]};
        end
        ddm_mixer #(.NOSC(DDC == 0 ? 3 : 1)) u_mix (
            .clk(CLOCK),
            .srst(SRST),
            .m(mif.mixer)
        );
        assign mix_i[b] = mif.i_out;
        assign mix_q[b] = mif.q_out;
    end

    ////////////////////////////////////////////////////////////////////////////
    // decimator: boxcar accumulate and dump, shared frame counter

    logic signed [20:0] acc_i_ff [4], acc_q_ff [4];
    logic signed [20:0] nxt_acc_i [4], nxt_acc_q [4];
    logic [5:0] cnt_ff, nxt_cnt;
    logic [10:0] flush_ff, nxt_flush;
    logic [8:0] cfg_ff;
    logic [127:0] dec_ff, nxt_dec;
    logic dec_v_ff, nxt_dec_v, dump, cfg_chg;

    assign dump = bypass || cnt_ff == ratio - 6'd1;
    assign flushing = flush_ff != 11'h000;
    assign cfg_chg = cfg_ff != {sel_a, sel_b, ctrl_ff[4:0]};

    always_comb begin
        logic signed [20:0] si, sq;
        si = 21'sh000000;
        sq = 21'sh000000;
        nxt_dec = dec_ff;
        nxt_cnt = dump ? 6'h00 : cnt_ff + 6'h01;
        // a new oscillator or ratio leaves stale data in the filter
        nxt_flush = flushing ? flush_ff - 11'h001 : 11'h000;
        if (cfg_chg) begin
            nxt_flush = latency;
            nxt_cnt = 6'h00;
        end
        for (int b = 0; b < 4; b++) begin
            si = acc_i_ff[b] + 21'(mix_i[b]);
            sq = acc_q_ff[b] + 21'(mix_q[b]);
            nxt_acc_i[b] = dump ? 21'sh000000 : si;
            nxt_acc_q[b] = dump ? 21'sh000000 : sq;
            if (dump) begin
                nxt_dec[32 * b +: 16] = 16'(si >>> dec_shift(ratio));
                nxt_dec[32 * b + 16 +: 16] = 16'(sq >>> dec_shift(ratio));
            end
        end
        if (bypass) begin
            nxt_dec = {16'h0000, 16'(smp_b_ff), 64'h0, 16'h0000, 16'(smp_a_ff)};
            nxt_dec[111:96] = 16'h0000;
            nxt_dec[47:32] = 16'h0000;
            nxt_dec[127:112] = 16'h0000;
            nxt_dec[95:80] = 16'(smp_b_ff) <<< 2;
            nxt_dec[79:64] = 16'h0000;
            nxt_dec[63:48] = 16'h0000;
            nxt_dec[31:16] = 16'h0000;
            nxt_dec[15:0] = 16'(smp_a_ff) <<< 2;
        end
        nxt_dec_v = dump && !flushing && !cfg_chg;
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            for (int b = 0; b < 4; b++) begin
                acc_i_ff[b] <= 21'sh000000;
                acc_q_ff[b] <= 21'sh000000;
            end
            cnt_ff <= 6'h00;
            flush_ff <= 11'h000;
            cfg_ff <= 9'h000;
            dec_ff <= 128'h0;
            dec_v_ff <= 1'b0;
        end else begin
            acc_i_ff <= nxt_acc_i;
            acc_q_ff <= nxt_acc_q;
            cnt_ff <= nxt_cnt;
            flush_ff <= nxt_flush;
            cfg_ff <= {sel_a, sel_b, ctrl_ff[4:0]};
            dec_ff <= nxt_dec;
            dec_v_ff <= nxt_dec_v;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // fixed-latency delay line; valid bits kept in flops so reset clears them

    logic [127:0] line_mem [LINE_DEPTH];
    logic [LINE_DEPTH-1:0] line_v_ff, nxt_line_v;
    logic [AW-1:0] wptr_ff, nxt_wptr, rptr;
    logic [127:0] dl_ff;
    logic dl_v_ff, nxt_dl_v, in_rdy_ff;

    // bypass skips the mixer register, so its tap sits one word deeper
    assign rptr = wptr_ff - AW'(latency - 11'(`DDM_PIPE) + {10'h000, bypass});
    assign nxt_wptr = wptr_ff + 1'b1;

    always_comb begin
        nxt_line_v = line_v_ff;
        nxt_line_v[wptr_ff] = dec_v_ff;
        // words of the old band still in the line must not reach the output
        if (cfg_chg) begin
            nxt_line_v = '0;
        end
        nxt_dl_v = line_v_ff[rptr] && !cfg_chg;
    end

    always_ff @(posedge CLOCK) begin
        line_mem[wptr_ff] <= dec_ff;
        if (!(dl_v_ff && !in_rdy_ff)) begin
            dl_ff <= line_mem[rptr];
        end
        if (SRST) begin
            line_v_ff <= '0;
            wptr_ff <= '0;
            dl_v_ff <= 1'b0;
        end else begin
            line_v_ff <= nxt_line_v;
            wptr_ff <= nxt_wptr;
            dl_v_ff <= nxt_dl_v;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // two-entry output buffer: output register plus skid register

    logic [127:0] out_ff, skid_ff, nxt_out, nxt_skid;
    logic out_v_ff, skid_v_ff, nxt_out_v, nxt_skid_v, push;

    assign in_rdy_ff = !skid_v_ff;
    assign push = dl_v_ff && in_rdy_ff;
    // the sample stream cannot stall; a word meeting a full buffer is lost and sets the sticky overrun flag
    assign overrun_set = dl_v_ff && !in_rdy_ff;

    always_comb begin
        nxt_out = out_ff;
        nxt_skid = skid_ff;
        nxt_out_v = out_v_ff;
        nxt_skid_v = skid_v_ff;
        if (OUT_READY || !out_v_ff) begin
            if (skid_v_ff) begin
                nxt_out = skid_ff;
                nxt_out_v = 1'b1;
                nxt_skid_v = 1'b0;
            end else begin
                nxt_out = push ? dl_ff : out_ff;
                nxt_out_v = push;
            end
        end else if (push) begin
            nxt_skid = dl_ff;
            nxt_skid_v = 1'b1;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            out_ff <= 128'h0;
            skid_ff <= 128'h0;
            out_v_ff <= 1'b0;
            skid_v_ff <= 1'b0;
        end else begin
            out_ff <= nxt_out;
            skid_ff <= nxt_skid;
            out_v_ff <= nxt_out_v;
            skid_v_ff <= nxt_skid_v;
        end
    end

    assign OUT_DATA = out_ff;
    assign OUT_VALID = out_v_ff;

endmodule : ddm_top

// ---- tb/ddm_top_checker.sv ----
`timescale 1ns/1ps
`include "ddm_defs.svh"
module ddm_top_checker (
    input wire logic CLOCK,
    input wire logic SRST,
    input wire logic [7:0] ADDRESS,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [31:0] WRITEDATA,
    input wire logic [31:0] READDATA,
    input wire logic WAITREQUEST,
    input wire logic [13:0] ADC_A,
    input wire logic [13:0] ADC_B,
    input wire logic [127:0] OUT_DATA,
    input wire logic OUT_VALID,
    input wire logic OUT_READY
);
    logic [10:0] ctrl_ff;
    logic [10:0] quiet_ff;
    logic [3:0] rdy_ff;
    logic settled;
    logic steady;
    logic acked_wr;
    assign acked_wr = WRITE && !WAITREQUEST;
    // judged only once every flush after the last write has run out
    assign settled = &quiet_ff;
    // a stall may leave old words in the buffer, so wait for a run of ready
    assign steady = &rdy_ff && OUT_READY;
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            ctrl_ff <= 11'h000;
            quiet_ff <= 11'h000;
            rdy_ff <= 4'h0;
        end else begin
            rdy_ff <= {rdy_ff[2:0], OUT_READY};
            quiet_ff <= acked_wr ? 11'h000 : quiet_ff + 11'(!settled);
            if (acked_wr && ADDRESS == `DDM_REG_CTRL) begin
                ctrl_ff <= WRITEDATA[10:0];
            end
        end
    end
////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (SRST);
    function automatic logic unmapped(input logic [7:0] a);
        return a[1:0] == 2'h0 && ((a > 8'h04 && a < 8'h40) || a > 8'hbc);
    endfunction
    sequence s_req;
        (READ || WRITE) && WAITREQUEST;
    endsequence
    sequence s_ack;
        !WAITREQUEST ##1 WAITREQUEST;
    endsequence
    chk_bus_answer: assert property (s_req |=> s_ack)
        else $error("bus answer not one cycle after request");
    chk_bus_quiet: assert property (!READ && !WRITE && WAITREQUEST |=> WAITREQUEST)
        else $error("bus answer without request");
    chk_reset_state: assert property ($past(SRST) |-> WAITREQUEST && !OUT_VALID
        && OUT_DATA == 128'h0 && READDATA == 32'h0)
        else $error("outputs wrong after reset");
    chk_ctrl_readback: assert property (READ && !WAITREQUEST
        && ADDRESS == `DDM_REG_CTRL |-> READDATA[10:0] == ctrl_ff)
        else $error("control read back differs");
    chk_unmapped_zero: assert property (READ && !WAITREQUEST
        && unmapped(ADDRESS) |-> READDATA == 32'h0)
        else $error("unmapped read not zero");
    chk_out_hold: assert property (OUT_VALID && !OUT_READY
        |=> OUT_VALID && $stable(OUT_DATA))
        else $error("output word not held in stall");
    chk_dec_gap: assert property (settled && !ctrl_ff[4] && steady && OUT_VALID
        |=> !OUT_VALID [*3])
        else $error("decimated words too close");
    chk_byp_stream: assert property (settled && ctrl_ff[4] && steady && OUT_VALID
        |=> OUT_VALID)
        else $error("bypass stream has a gap");
    chk_byp_data: assert property (settled && ctrl_ff[4] && !ctrl_ff[5] && steady
        && OUT_VALID |-> OUT_DATA[15:0] == {$past(ADC_A, `DDM_LAT_BYPASS), 2'b00}
        && OUT_DATA[95:80] == {$past(ADC_B, `DDM_LAT_BYPASS), 2'b00}
        && OUT_DATA[79:16] == 64'h0 && OUT_DATA[127:96] == 32'h0)
        else $error("bypass word wrong or late");
endmodule : ddm_top_checker

// ---- tb/ddm_partner.sv ----
`timescale 1ns/1ps
module ddm_partner (
    input wire logic clk,
    input wire logic stall,
    output logic [13:0] adc_a,
    output logic [13:0] adc_b,
    output logic ready
);
    // fresh samples every edge; the receiver stalls at random only when asked
    always @(posedge clk) begin
        adc_a <= 14'($urandom);
        adc_b <= 14'($urandom);
        ready <= stall ? 1'($urandom) : 1'b1;
    end
endmodule : ddm_partner

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`include "ddm_defs.svh"
module tb_top;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic link = 1'b0;
    logic stall = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [1:0] pin_a = 2'h0;
    logic [1:0] pin_b = 2'h0;
    logic [31:0] rdata;
    logic waitreq;
    logic out_valid;
    logic ready;
    logic [13:0] adc_a;
    logic [13:0] adc_b;
    logic [127:0] out_data;
    int failures = 0;
    int samples_checked = 0;
    always #4 clk = ~clk;
    ddm_partner ddm_partner_inst (.clk(clk), .stall(stall), .adc_a(adc_a), .adc_b(adc_b),
        .ready(ready));
    ddm_top #(.LINE_DEPTH(2048)) ddm_top_inst (.CLOCK(clk), .SRST(srst), .ADDRESS(addr),
        .READ(rd), .WRITE(wr), .WRITEDATA(wdata), .READDATA(rdata), .WAITREQUEST(waitreq),
        .ADC_A(adc_a), .ADC_B(adc_b), .OSC_SEL_A_PIN(pin_a), .OSC_SEL_B_PIN(pin_b),
        .LINK_UP(link), .OUT_DATA(out_data), .OUT_VALID(out_valid), .OUT_READY(ready));
////////////////////////////////////////////////////////////////////////////////
    function automatic int ratio_of(input int c);
        int r [11] = '{4, 6, 8, 9, 10, 12, 16, 18, 20, 24, 32};
        return r[c];
    endfunction : ratio_of
    function automatic int lat_of(input int c);
        int l [11] = '{`DDM_LAT_D4, `DDM_LAT_D6, `DDM_LAT_D8, `DDM_LAT_D9, `DDM_LAT_D10,
            `DDM_LAT_D12, `DDM_LAT_D16, `DDM_LAT_D18, `DDM_LAT_D20, `DDM_LAT_D24,
            `DDM_LAT_D32};
        return l[c];
    endfunction : lat_of
    task automatic final_report();
        $display("compared %0d, mismatched %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        chk("bus answer", 32'd2, n);
    endtask : bus
    task automatic take(output logic [127:0] d);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!(out_valid === 1'b1 && ready === 1'b1) && n < 4000);
        d = out_data;
        chk("word arrives", 32'h1, n < 4000);
    endtask : take
////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] q;
        logic [127:0] d;
        int c;
        int n;
        int r;
        void'($urandom(32'hbfe05f13));
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        bus(0, 8'h20, 32'h0, q);
        chk("unmapped", 32'h0, q);
        link <= 1'b1;
        r = $urandom_range(16'hffff);
        // oscillator 2 on both channels; oscillator 1 stays at zero frequency
        for (n = 0; n < 4; n++) begin
            c = (n / 2) * 64 + 8 + (n % 2) * 4;
            bus(1, 8'h40 + 8'(c), (n % 2) ? r[15:8] : r[7:0], q);
            bus(0, 8'h40 + 8'(c), 32'h0, q);
            chk("word byte", (n % 2) ? r[15:8] : r[7:0], q & 32'hff);
        end
        bus(0, `DDM_REG_STATUS, 32'h0, q);
        chk("nondet flag", 32'h1, q[`DDM_S_NONDET]);
        link <= 1'b0;
        bus(1, `DDM_REG_STATUS, 32'h2, q);
        bus(0, `DDM_REG_STATUS, 32'h0, q);
        chk("nondet clear", 32'h0, q[`DDM_S_NONDET]);
        bus(1, `DDM_REG_CTRL, 32'hf, q);
        bus(0, `DDM_REG_STATUS, 32'h0, q);
        chk("bad ratio", 32'h1, q[`DDM_S_BADCFG]);
        chk("flushing", 32'h1, q[`DDM_S_FLUSH]);
        for (c = 0; c < 11; c++) begin
            bus(1, `DDM_REG_CTRL, c, q);
            // a word of the old setting may still sit in the buffer
            repeat (8) @(posedge clk);
            n = 0;
            while (out_valid !== 1'b1 && n < 4000) begin
                @(posedge clk);
                n++;
            end
            // the flush runs one latency, then the line adds its own
            r = 2 * lat_of(c);
            chk("latency", 32'h1, n + 16 >= r && n <= r + ratio_of(c));
            n = 0;
            repeat (16 * ratio_of(c)) begin
                @(posedge clk);
                n += int'(out_valid === 1'b1);
            end
            chk("rate", 32'd16, n);
        end
        for (c = 0; c < 3; c++) begin
            pin_a <= (c == 2) ? 2'b01 : 2'b11;
            bus(1, `DDM_REG_CTRL, (c == 0) ? 32'h22 : 32'h62, q);
            for (n = 0; n < 6; n++) begin
                take(d);
                if (n > 1 && c == 0) chk("mux band", d[95:64], d[31:0]);
                if (n > 1 && c == 1) chk("sel none", 32'h0, d[31:0]);
                if (n > 1 && c == 2) chk("sel osc2", 32'h1, d[31:0] !== d[95:64]);
            end
        end
        stall <= 1'b1;
        bus(1, `DDM_REG_CTRL, 32'h10, q);
        repeat (3000) @(posedge clk);
        bus(0, `DDM_REG_STATUS, 32'h0, q);
        chk("overrun", 32'h1, q[`DDM_S_OVERRUN]);
        stall <= 1'b0;
        repeat (8) @(posedge clk);
        bus(1, `DDM_REG_STATUS, 32'h1, q);
        n = 0;
        // long enough for the checker's settle window to open on the stream
        repeat (2600) begin
            @(posedge clk);
            n += int'(out_valid === 1'b1);
        end
        chk("bypass stream", 32'd2600, n);
        bus(0, `DDM_REG_STATUS, 32'h0, q);
        chk("overrun clear", 32'h0, q[`DDM_S_OVERRUN]);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        bus(0, `DDM_REG_CTRL, 32'h0, q);
        chk("ctrl reset", `DDM_CTRL_RESET, q);
        final_report();
    end
    // the sequence needs about 32000 cycles; allow roughly two and a half times that
    initial begin
        #640000;
        failures++;
        final_report();
    end
endmodule : tb_top
bind ddm_top ddm_top_checker ddm_top_checker_inst (.CLOCK(CLOCK), .SRST(SRST),
    .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA),
    .READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .ADC_A(ADC_A), .ADC_B(ADC_B),
    .OUT_DATA(OUT_DATA), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY));
